// File: design/iid_cycle_timer.sv
// Execution cycle timer: counts a loaded figure down to a done pulse
`timescale 1ns/1ps
module iid_cycle_timer (
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic       load,
	input  wire logic [7:0] count,
	output logic            last,
	output logic            done
);
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic       next_done;

	// Last cycle of the run, lets the caller retire in step with done
	assign last = (cnt == 8'h01);

	// Next count and pulse
	always_comb begin
		next_cnt  = cnt;
		next_done = 1'b0;
		if (load) begin
			next_cnt = count;
		end else if (last) begin
			next_cnt  = 8'h00;
			next_done = 1'b1;
		end else if (cnt != 8'h00) begin
			next_cnt = cnt - 8'h01;
		end
	end

	// Registers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cnt  <= 8'h00;
			done <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			done <= next_done;
		end
	end
endmodule

// File: design/iid_decode.sv
// Instruction subset decoder with flag effects and cycle timing
`timescale 1ns/1ps
// Contract
// [RULE_01] 37 decodes ascii_add_adjust, 3 cycles, AF CF
// [RULE_02] 3F decodes ascii_subtract_adjust, 3 cycles, same flags
// [RULE_03] D5 0A ascii_divide_prep, 7 cycles, SF ZF PF
// [RULE_04] D4 0A ascii_multiply_adjust, 19 cycles, same flags
// [RULE_05] Nibble 1 is add with carry, one cycle
// [RULE_06] 8x group op chosen by ModR/M reg
// [RULE_07] Nibble 0 is integer sum, all six flags
// [RULE_08] Nibble 2 conjunction clears overflow and carry
// [RULE_09] 63 privilege adjust, 9 cycles protected, zero only
// [RULE_10] 0F 3A rewinds blit buffer 0, 2 cycles
// [RULE_11] 0F 3B rewinds blit buffer 1, 2 cycles
// [RULE_12] 62 bound check: 7 in range, 8+vector 5
// [RULE_13] 0F BC forward scan 4 or 9+n, zero
// [RULE_14] 0F BD reverse scan 4 or 11+n, zero
// [RULE_15] Bit test BA/100 or A3, carry only
// [RULE_16] Complement BA/111 or BB, 2 or 8; the code gives the BA memory form 2
// [RULE_17] Clear BA/110 or B3, 2 or 8; the code gives the BA memory form 2
// [RULE_18] Set BA/101 or AB, 2 or 8; the code gives the BA memory form 2
// [RULE_19] Flags: update, keep, force value, or undefined
// [RULE_20] n adds one cycle per repetition
// [RULE_21] Full immediate is 8, 16 or 32 bits
// [RULE_22] Slash counts: register first, memory second
// [RULE_23] d direction, w width, s sign-extend
module iid_decode (
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	input  wire logic             byte_valid,
	input  wire logic [7:0]       byte_data,
	input  wire logic             prot_mode,
	input  wire logic             op_size32,
	input  wire logic [4:0]       scan_reps,
	input  wire logic             bound_in_range,
	output logic                  byte_ready,
	output logic                  busy,
	output iid_pkg::iid_op_t      op,
	output logic [7:0]            cycles,
	output logic [2:0]            imm_len,
	output logic                  dir_to_reg,
	output logic                  wide,
	output logic                  mem_operand,
	output logic [8:0]            flag_update,
	output logic [8:0]            flag_force,
	output logic [8:0]            flag_force_val,
	output logic [8:0]            flag_undef,
	output logic                  exec_done,
	output logic                  blit0_rewind,
	output logic                  blit1_rewind,
	output logic                  bound_fault,
	output logic [7:0]            int_vector,
	output logic                  unsupported
);
	import iid_pkg::*;

	typedef enum logic [2:0] {
		ST_OPCODE, ST_ESCAPE, ST_ASCII2, ST_MODRM, ST_EXEC
	} iid_state_t;

	iid_state_t state, next_state;
	iid_op_t    next_op;
	logic [7:0] first, next_first;
	logic [7:0] next_cycles, next_vector;
	logic [2:0] next_imm;
	logic       next_dir, next_wide, next_mem, next_ready, next_unsup;
	logic       next_blit0, next_blit1, next_fault;
	logic [8:0] next_upd, next_frc, next_val, next_und;
	logic       take, start, t_last;
	iid_fx_t    fx;

	// Flag effects per operation; unmarked flags are kept
	function automatic iid_fx_t flag_fx(input iid_op_t o);
		iid_fx_t f;
		f = '{FLG_NONE, FLG_NONE, FLG_NONE, FLG_NONE};
		case (o)
			OP_ASCII_ADD, OP_ASCII_SUB: begin // [RULE_01] [RULE_02]
				f.upd[FLG_AUX]      = 1'b1;
				f.upd[FLG_CARRY]    = 1'b1;
				f.und[FLG_OVERFLOW] = 1'b1;
				f.und[FLG_SIGN]     = 1'b1;
				f.und[FLG_ZERO]     = 1'b1;
				f.und[FLG_PARITY]   = 1'b1;
			end
			OP_ASCII_DIV, OP_ASCII_MUL: begin // [RULE_03] [RULE_04]
				f.upd[FLG_SIGN]     = 1'b1;
				f.upd[FLG_ZERO]     = 1'b1;
				f.upd[FLG_PARITY]   = 1'b1;
				f.und[FLG_OVERFLOW] = 1'b1;
				f.und[FLG_AUX]      = 1'b1;
				f.und[FLG_CARRY]    = 1'b1;
			end
			OP_ADC, OP_SUM: begin // [RULE_05] [RULE_07]
				f.upd[FLG_OVERFLOW] = 1'b1;
				f.upd[FLG_SIGN]     = 1'b1;
				f.upd[FLG_ZERO]     = 1'b1;
				f.upd[FLG_AUX]      = 1'b1;
				f.upd[FLG_PARITY]   = 1'b1;
				f.upd[FLG_CARRY]    = 1'b1;
			end
			OP_AND: begin // [RULE_08]
				f.frc[FLG_OVERFLOW] = 1'b1;
				f.frc[FLG_CARRY]    = 1'b1;
				f.upd[FLG_SIGN]     = 1'b1;
				f.upd[FLG_ZERO]     = 1'b1;
				f.upd[FLG_PARITY]   = 1'b1;
				f.und[FLG_AUX]      = 1'b1;
			end
			OP_PRIV_ADJ, OP_SCAN_FWD, OP_SCAN_REV: begin // [RULE_09] [RULE_13] [RULE_14]
				f.upd[FLG_ZERO] = 1'b1;
			end
			OP_BIT_TST, OP_BIT_CMP, OP_BIT_CLR, OP_BIT_SET: begin // [RULE_15] [RULE_16] [RULE_17] [RULE_18]
				f.upd[FLG_CARRY] = 1'b1;
			end
			default: begin // Blit rewinds and bound check touch nothing [RULE_10] [RULE_11] [RULE_12] [RULE_19]
				f.upd = FLG_NONE;
			end
		endcase
		return f;
	endfunction

	// Full immediate: one byte, or word or dword by operand size
	function automatic logic [2:0] full_imm(input logic w);
		if (!w)
			return IMM_BYTE;
		return op_size32 ? IMM_DWORD : IMM_WORD; // [RULE_21]
	endfunction

	assign take = byte_valid && byte_ready;

	iid_cycle_timer u_timer (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.load    (start),
		.count   (next_cycles),
		.last    (t_last),
		.done    (exec_done)
	);

	// Byte-walk decoder; results latch when the last byte is taken
	always_comb begin
		next_state  = state;
		next_first  = first;
		next_op     = op;
		next_cycles = cycles;
		next_imm    = imm_len;
		next_dir    = dir_to_reg;
		next_wide   = wide;
		next_mem    = mem_operand;
		next_vector = int_vector;
		next_unsup  = 1'b0;
		next_fault  = 1'b0;
		start       = 1'b0;
		case (state)
			ST_OPCODE: begin
				if (take) begin
					next_first = byte_data;
					next_imm   = IMM_NONE;
					next_mem   = 1'b0;
					next_dir   = 1'b0;
					next_wide  = 1'b0;
					if (byte_data == OPC_ASCII_ADD || byte_data == OPC_ASCII_SUB) begin
						next_op     = (byte_data == OPC_ASCII_ADD) ? OP_ASCII_ADD : OP_ASCII_SUB; // [RULE_01] [RULE_02]
						next_cycles = CYC_ASCII_ADD;
						start       = 1'b1;
					end else if (byte_data == OPC_ASCII_DIV || byte_data == OPC_ASCII_MUL) begin
						next_state = ST_ASCII2;
					end else if (byte_data == OPC_ESCAPE) begin
						next_state = ST_ESCAPE;
					end else if ((byte_data[7:4] == NIB_SUM || byte_data[7:4] == NIB_ADC
						|| byte_data[7:4] == NIB_AND) && !byte_data[3]
						&& byte_data[2:1] != 2'b11) begin
						// [RULE_05] [RULE_07] [RULE_08] [RULE_23]
						next_op   = (byte_data[7:4] == NIB_SUM) ? OP_SUM :
							(byte_data[7:4] == NIB_ADC) ? OP_ADC : OP_AND;
						next_wide = byte_data[0];
						next_dir  = byte_data[1] && !byte_data[2];
						if (byte_data[2]) begin
							next_imm    = full_imm(byte_data[0]);
							next_cycles = CYC_ALU;
							start       = 1'b1;
						end else begin
							next_state = ST_MODRM;
						end
					end else if (byte_data[7:2] == {NIB_IMM_GRP, 2'b00}) begin
						next_wide  = byte_data[0];
						// Sign-extended form carries only one byte [RULE_23]
						next_imm   = byte_data[1] ? IMM_BYTE : full_imm(byte_data[0]);
						next_state = ST_MODRM;
					end else if (byte_data == OPC_PRIV_ADJ || byte_data == OPC_ARRAY_LIM) begin
						next_state = ST_MODRM;
					end else begin
						next_op    = OP_NONE;
						next_unsup = 1'b1;
					end
				end
			end
			ST_ASCII2: begin
				if (take) begin
					next_state = ST_OPCODE;
					if (byte_data == OPC_ASCII_BASE) begin
						next_op     = (first == OPC_ASCII_DIV) ? OP_ASCII_DIV : OP_ASCII_MUL; // [RULE_03] [RULE_04]
						next_cycles = (first == OPC_ASCII_DIV) ? CYC_ASCII_DIV : CYC_ASCII_MUL;
						start       = 1'b1;
					end else begin
						next_op    = OP_NONE;
						next_unsup = 1'b1;
					end
				end
			end
			ST_ESCAPE: begin
				if (take) begin
					next_first = byte_data;
					next_state = ST_MODRM;
					case (byte_data)
						OPC_BLIT0, OPC_BLIT1: begin // [RULE_10] [RULE_11]
							next_op     = (byte_data == OPC_BLIT0) ? OP_BLIT0 : OP_BLIT1;
							next_cycles = CYC_BLIT;
							next_state  = ST_OPCODE;
							start       = 1'b1;
						end
						OPC_BIT_IMM: next_imm = IMM_BYTE;
						OPC_SCAN_FWD, OPC_SCAN_REV, OPC_BIT_TST_R,
						OPC_BIT_CMP_R, OPC_BIT_CLR_R, OPC_BIT_SET_R: next_imm = IMM_NONE;
						default: begin
							next_op    = OP_NONE;
							next_state = ST_OPCODE;
							next_unsup = 1'b1;
						end
					endcase
				end
			end
			ST_MODRM: begin
				if (take) begin
					next_state = ST_OPCODE;
					next_mem   = (byte_data[7:6] != MOD_REGISTER);
					start      = 1'b1;
					next_cycles = CYC_ALU;
					if (first[7:4] == NIB_IMM_GRP) begin // [RULE_06]
						case (byte_data[5:3])
							REG_SUM: next_op = OP_SUM;
							REG_ADC: next_op = OP_ADC;
							REG_AND: next_op = OP_AND;
							default: next_op = OP_NONE;
						endcase
					end else if (first == OPC_PRIV_ADJ) begin
						next_op     = prot_mode ? OP_PRIV_ADJ : OP_NONE; // [RULE_09]
						next_cycles = CYC_PRIV_ADJ;
					end else if (first == OPC_ARRAY_LIM) begin // [RULE_12]
						next_op     = OP_ARRAY_LIM;
						next_cycles = bound_in_range ? CYC_LIM_IN : CYC_LIM_OUT;
					end else if (first == OPC_SCAN_FWD || first == OPC_SCAN_REV) begin
						// Memory scans add one cycle per repetition [RULE_13] [RULE_14] [RULE_20] [RULE_22]
						next_op     = (first == OPC_SCAN_FWD) ? OP_SCAN_FWD : OP_SCAN_REV;
						next_cycles = !next_mem ? CYC_SCAN_REG :
							((first == OPC_SCAN_FWD) ? CYC_SCAN_FWD_M : CYC_SCAN_REV_M)
							+ {3'h0, scan_reps};
					end else if (first == OPC_BIT_IMM) begin
						case (byte_data[5:3])
							REG_BIT_TST: next_op = OP_BIT_TST; // [RULE_15]
							REG_BIT_CMP: next_op = OP_BIT_CMP; // [RULE_16]
							REG_BIT_CLR: next_op = OP_BIT_CLR; // [RULE_17]
							REG_BIT_SET: next_op = OP_BIT_SET; // [RULE_18]
							default:     next_op = OP_NONE;
						endcase
						// Immediate index forms cost the register figure
						next_cycles = (next_op == OP_BIT_TST) ? CYC_TST_REG : CYC_MOD_REG;
					end else if (first == OPC_BIT_TST_R) begin
						next_op     = OP_BIT_TST;
						next_cycles = next_mem ? CYC_TST_MEM : CYC_TST_REG; // [RULE_15] [RULE_22]
					end else if (first == OPC_BIT_CMP_R || first == OPC_BIT_CLR_R
						|| first == OPC_BIT_SET_R) begin
						next_op     = (first == OPC_BIT_CMP_R) ? OP_BIT_CMP :
							(first == OPC_BIT_CLR_R) ? OP_BIT_CLR : OP_BIT_SET;
						next_cycles = next_mem ? CYC_MOD_MEM : CYC_MOD_REG; // [RULE_16] [RULE_17] [RULE_18]
					end
					// Unknown reg field, or privilege adjust in real mode
					if (next_op == OP_NONE) begin
						start      = 1'b0;
						next_unsup = 1'b1;
					end
				end
			end
			ST_EXEC: begin
				if (t_last) begin
					next_state  = ST_OPCODE;
					next_fault  = (op == OP_ARRAY_LIM) && (cycles == CYC_LIM_OUT); // [RULE_12]
					next_vector = next_fault ? LIMIT_VECTOR : int_vector;
				end
			end
			default: next_state = ST_OPCODE;
		endcase
		if (start)
			next_state = ST_EXEC;
		// Flag outputs follow the newly decoded operation
		fx         = flag_fx(next_op);
		next_upd   = start ? fx.upd : flag_update;
		next_frc   = start ? fx.frc : flag_force;
		next_val   = start ? fx.val : flag_force_val;
		next_und   = start ? fx.und : flag_undef;
		next_ready = (next_state != ST_EXEC);
		next_blit0 = (state == ST_EXEC) && t_last && (op == OP_BLIT0); // [RULE_10]
		next_blit1 = (state == ST_EXEC) && t_last && (op == OP_BLIT1); // [RULE_11]
	end

	// State and output registers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state          <= ST_OPCODE;
			first          <= 8'h00;
			op             <= OP_NONE;
			cycles         <= 8'h00;
			imm_len        <= IMM_NONE;
			dir_to_reg     <= 1'b0;
			wide           <= 1'b0;
			mem_operand    <= 1'b0;
			flag_update    <= FLG_NONE;
			flag_force     <= FLG_NONE;
			flag_force_val <= FLG_NONE;
			flag_undef     <= FLG_NONE;
			byte_ready     <= 1'b0;
			busy           <= 1'b0;
			blit0_rewind   <= 1'b0;
			blit1_rewind   <= 1'b0;
			bound_fault    <= 1'b0;
			int_vector     <= 8'h00;
			unsupported    <= 1'b0;
		end else begin
			state          <= next_state;
			first          <= next_first;
			op             <= next_op;
			cycles         <= next_cycles;
			imm_len        <= next_imm;
			dir_to_reg     <= next_dir;
			wide           <= next_wide;
			mem_operand    <= next_mem;
			flag_update    <= next_upd;
			flag_force     <= next_frc;
			flag_force_val <= next_val;
			flag_undef     <= next_und;
			byte_ready     <= next_ready;
			busy           <= (next_state == ST_EXEC);
			blit0_rewind   <= next_blit0;
			blit1_rewind   <= next_blit1;
			bound_fault    <= next_fault;
			int_vector     <= next_vector;
			unsupported    <= next_unsup;
		end
	end

	// Timing and effect checks
	property p_ascii_add_time;
		@(posedge clk_sys) disable iff (!rstn)
		start && next_op == OP_ASCII_ADD |->
			##3 (!exec_done && busy) ##1 exec_done;
	endproperty
	a_ascii_add_time: assert property (p_ascii_add_time) else $error("ascii add not 3 cycles"); // [RULE_01]

	property p_ascii_mul_time;
		@(posedge clk_sys) disable iff (!rstn)
		start && next_op == OP_ASCII_MUL |-> ##20 exec_done;
	endproperty
	a_ascii_mul_time: assert property (p_ascii_mul_time) else $error("multiply adjust not 19 cycles"); // [RULE_04]

	property p_ascii_div_flags;
		@(posedge clk_sys) disable iff (!rstn)
		start && next_op == OP_ASCII_DIV |=>
			(flag_update == 9'h01a && flag_undef == 9'h105) ##7 exec_done;
	endproperty
	a_ascii_div_flags: assert property (p_ascii_div_flags) else $error("divide prep flags or time wrong"); // [RULE_03]

	property p_and_forces;
		@(posedge clk_sys) disable iff (!rstn)
		start && next_op == OP_AND |=> flag_force == 9'h101 && flag_force_val == 9'h000 && busy;
	endproperty
	a_and_forces: assert property (p_and_forces) else $error("conjunction does not clear overflow and carry"); // [RULE_08]

	property p_priv_real;
		@(posedge clk_sys) disable iff (!rstn)
		state == ST_MODRM && take && first == OPC_PRIV_ADJ && !prot_mode |=> unsupported && !busy;
	endproperty
	a_priv_real: assert property (p_priv_real) else $error("privilege adjust accepted in real mode"); // [RULE_09]

	property p_blit0;
		@(posedge clk_sys) disable iff (!rstn)
		start && next_op == OP_BLIT0 |->
			##3 (exec_done && blit0_rewind && !blit1_rewind);
	endproperty
	a_blit0: assert property (p_blit0) else $error("blit buffer 0 rewind not at cycle 2"); // [RULE_10]

	property p_bound_out;
		@(posedge clk_sys) disable iff (!rstn)
		start && next_op == OP_ARRAY_LIM && !bound_in_range |->
			##9 (bound_fault && int_vector == 8'h05);
	endproperty
	a_bound_out: assert property (p_bound_out) else $error("out of range bound check missed vector 5"); // [RULE_12]

	property p_scan_reg;
		@(posedge clk_sys) disable iff (!rstn)
		start && next_op == OP_SCAN_FWD && !next_mem |-> ##5 exec_done;
	endproperty
	a_scan_reg: assert property (p_scan_reg) else $error("register scan not 4 cycles"); // [RULE_13]

	property p_bit_carry;
		@(posedge clk_sys) disable iff (!rstn)
		start && next_op == OP_BIT_SET |=> flag_update == 9'h001 && (cycles == 8'h02 || cycles == 8'h08);
	endproperty
	a_bit_carry: assert property (p_bit_carry) else $error("bit set flags or count wrong"); // [RULE_18]
endmodule

// File: design/iid_pkg.sv
// Package: opcodes, cycle counts, flag layout and types for the decoder
package iid_pkg;

	// Single and leading opcode bytes
	localparam logic [7:0] OPC_ASCII_ADD   = 8'h37;
	localparam logic [7:0] OPC_ASCII_SUB   = 8'h3f;
	localparam logic [7:0] OPC_ASCII_DIV   = 8'hd5;
	localparam logic [7:0] OPC_ASCII_MUL   = 8'hd4;
	localparam logic [7:0] OPC_ASCII_BASE  = 8'h0a;
	localparam logic [7:0] OPC_PRIV_ADJ    = 8'h63;
	localparam logic [7:0] OPC_ARRAY_LIM   = 8'h62;
	localparam logic [7:0] OPC_ESCAPE      = 8'h0f;
	// Second bytes after the escape
	localparam logic [7:0] OPC_BLIT0       = 8'h3a;
	localparam logic [7:0] OPC_BLIT1       = 8'h3b;
	localparam logic [7:0] OPC_SCAN_FWD    = 8'hbc;
	localparam logic [7:0] OPC_SCAN_REV    = 8'hbd;
	localparam logic [7:0] OPC_BIT_IMM     = 8'hba;
	localparam logic [7:0] OPC_BIT_TST_R   = 8'ha3;
	localparam logic [7:0] OPC_BIT_CMP_R   = 8'hbb;
	localparam logic [7:0] OPC_BIT_CLR_R   = 8'hb3;
	localparam logic [7:0] OPC_BIT_SET_R   = 8'hab;
	// Upper nibbles of the arithmetic families
	localparam logic [3:0] NIB_SUM         = 4'h0;
	localparam logic [3:0] NIB_ADC         = 4'h1;
	localparam logic [3:0] NIB_AND         = 4'h2;
	localparam logic [3:0] NIB_IMM_GRP     = 4'h8;
	// ModR/M reg field selectors
	localparam logic [2:0] REG_SUM         = 3'h0;
	localparam logic [2:0] REG_ADC         = 3'h2;
	localparam logic [2:0] REG_AND         = 3'h4;
	localparam logic [2:0] REG_BIT_TST     = 3'h4;
	localparam logic [2:0] REG_BIT_SET     = 3'h5;
	localparam logic [2:0] REG_BIT_CLR     = 3'h6;
	localparam logic [2:0] REG_BIT_CMP     = 3'h7;
	localparam logic [1:0] MOD_REGISTER    = 2'h3;

	// Cycle counts on a cache hit
	localparam logic [7:0] CYC_ASCII_ADD   = 8'h03;
	localparam logic [7:0] CYC_ASCII_DIV   = 8'h07;
	localparam logic [7:0] CYC_ASCII_MUL   = 8'h13;
	localparam logic [7:0] CYC_ALU         = 8'h01;
	localparam logic [7:0] CYC_PRIV_ADJ    = 8'h09;
	localparam logic [7:0] CYC_BLIT        = 8'h02;
	localparam logic [7:0] CYC_LIM_IN      = 8'h07;
	localparam logic [7:0] CYC_LIM_OUT     = 8'h08;
	localparam logic [7:0] CYC_SCAN_REG    = 8'h04;
	localparam logic [7:0] CYC_SCAN_FWD_M  = 8'h09;
	localparam logic [7:0] CYC_SCAN_REV_M  = 8'h0b;
	localparam logic [7:0] CYC_TST_REG     = 8'h01;
	localparam logic [7:0] CYC_TST_MEM     = 8'h07;
	localparam logic [7:0] CYC_MOD_REG     = 8'h02;
	localparam logic [7:0] CYC_MOD_MEM     = 8'h08;
	localparam logic [7:0] LIMIT_VECTOR    = 8'h05;

	// Immediate lengths in bytes
	localparam logic [2:0] IMM_NONE        = 3'h0;
	localparam logic [2:0] IMM_BYTE        = 3'h1;
	localparam logic [2:0] IMM_WORD        = 3'h2;
	localparam logic [2:0] IMM_DWORD       = 3'h4;

	// Flag vector bit positions
	localparam int FLG_OVERFLOW  = 8;
	localparam int FLG_DIRECTION = 7;
	localparam int FLG_INTERRUPT = 6;
	localparam int FLG_TRAP      = 5;
	localparam int FLG_SIGN      = 4;
	localparam int FLG_ZERO      = 3;
	localparam int FLG_AUX       = 2;
	localparam int FLG_PARITY    = 1;
	localparam int FLG_CARRY     = 0;
	localparam logic [8:0] FLG_NONE = 9'h000;

	typedef enum logic [4:0] {
		OP_NONE, OP_ASCII_ADD, OP_ASCII_SUB, OP_ASCII_DIV, OP_ASCII_MUL,
		OP_ADC, OP_SUM, OP_AND, OP_PRIV_ADJ, OP_BLIT0, OP_BLIT1,
		OP_ARRAY_LIM, OP_SCAN_FWD, OP_SCAN_REV, OP_BIT_TST, OP_BIT_CMP,
		OP_BIT_CLR, OP_BIT_SET
	} iid_op_t;

	// Per-flag effect: update, force, forced value, undefined
	typedef struct packed {
		logic [8:0] upd;
		logic [8:0] frc;
		logic [8:0] val;
		logic [8:0] und;
	} iid_fx_t;

endpackage

// File: test/iid_fetch_model.sv
// Fetch-side model: offers instruction bytes and holds each until taken
`timescale 1ns/1ps
module iid_fetch_model (
	input  wire logic       clk_sys,
	input  wire logic       byte_ready,
	output logic            byte_valid,
	output logic [7:0]      byte_data
);
	// Quiet line at time zero
	initial begin
		byte_valid = 1'b0;
		byte_data  = 8'h00;
	end
	// Release at once; idle data is inverted so no stale byte looks valid
	task automatic drop();
		byte_valid = 1'b0;
		byte_data  = ~byte_data;
	endtask
	// Offer a byte after gap idle cycles, hold it to the accepting edge
	task automatic send(input logic [7:0] b, input int gap);
		if (gap > 0) begin
			@(negedge clk_sys);
			drop();
			repeat (gap - 1) @(negedge clk_sys);
		end
		@(negedge clk_sys);
		byte_valid = 1'b1;
		byte_data  = b;
		// Ready seen low at the falling edge means no take at the next rise
		while (byte_ready !== 1'b1) @(negedge clk_sys);
		@(posedge clk_sys);
	endtask
endmodule

// File: test/iid_tb.sv
// Self-checking bench for the instruction subset decoder
`timescale 1ns/1ps
module tb;
	import iid_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rstn, prot_mode, op_size32, bound_in_range;
	logic [4:0]  scan_reps;
	logic        byte_valid, byte_ready, exec_done, unsupported;
	logic        busy, wide, dir_to_reg, mem_operand;
	logic [2:0]  imm_len;
	logic        blit0_rewind, blit1_rewind, bound_fault;
	logic [7:0]  byte_data, cycles, int_vector;
	logic [8:0]  flag_update, flag_force, flag_force_val, flag_undef;
	iid_op_t     op;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          cyc = 0;
	logic [31:0] seed = 32'h00016e92;
	// Entry: bytes b0 b1 b2, flags {real, modrm last, count}
	logic [31:0] tbl [27] = '{32'h37000001, 32'h3f000001, 32'hd50a0002,
		32'hd40a0002, 32'h01c00012, 32'h13000012, 32'h25000001,
		32'h81100012, 32'h83200012, 32'h80000012, 32'h63000012,
		32'h63000092, 32'h0f3a0002, 32'h0f3b0002, 32'h62000012,
		32'h0fbc0013, 32'h0fbd0013, 32'h0fba2013, 32'h0fa30013,
		32'h0fba3813, 32'h0fbb0013, 32'h0fba3013, 32'h0fb30013,
		32'h0fba2813, 32'h0fab0013, 32'hd5000002, 32'h0fba0013};
	iid_op_t     xops [27] = '{OP_ASCII_ADD, OP_ASCII_SUB, OP_ASCII_DIV,
		OP_ASCII_MUL, OP_SUM, OP_ADC, OP_AND, OP_ADC, OP_AND, OP_SUM,
		OP_PRIV_ADJ, OP_NONE, OP_BLIT0, OP_BLIT1, OP_ARRAY_LIM,
		OP_SCAN_FWD, OP_SCAN_REV, OP_BIT_TST, OP_BIT_TST, OP_BIT_CMP,
		OP_BIT_CMP, OP_BIT_CLR, OP_BIT_CLR, OP_BIT_SET, OP_BIT_SET,
		OP_NONE, OP_NONE};

	iid_decode dut (.clk_sys(clk_sys), .rstn(rstn), .byte_valid(byte_valid),
		.byte_data(byte_data), .prot_mode(prot_mode), .op_size32(op_size32),
		.scan_reps(scan_reps), .bound_in_range(bound_in_range),
		.byte_ready(byte_ready), .busy(busy), .op(op), .cycles(cycles),
		.imm_len(imm_len), .dir_to_reg(dir_to_reg), .wide(wide),
		.mem_operand(mem_operand),
		.flag_update(flag_update), .flag_force(flag_force),
		.flag_force_val(flag_force_val), .flag_undef(flag_undef),
		.exec_done(exec_done), .blit0_rewind(blit0_rewind),
		.blit1_rewind(blit1_rewind), .bound_fault(bound_fault),
		.int_vector(int_vector), .unsupported(unsupported));
	iid_fetch_model fetch (.clk_sys(clk_sys), .byte_ready(byte_ready),
		.byte_valid(byte_valid), .byte_data(byte_data));

	always #5 clk_sys = ~clk_sys;
	// Hang guard, far above two passes of the table
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Expected {update, force, forced value, undefined}
	function automatic logic [35:0] fx(input iid_op_t o);
		case (o)
			OP_ASCII_ADD, OP_ASCII_SUB: return {9'h005, 18'h0, 9'h11a};
			OP_ASCII_DIV, OP_ASCII_MUL: return {9'h01a, 18'h0, 9'h105};
			OP_ADC, OP_SUM:             return {9'h11f, 27'h0};
			OP_AND:                     return {9'h01a, 9'h101, 9'h0, 9'h004};
			OP_PRIV_ADJ, OP_SCAN_FWD, OP_SCAN_REV: return {9'h008, 27'h0};
			OP_BIT_TST, OP_BIT_CMP, OP_BIT_CLR, OP_BIT_SET:
				return {9'h001, 27'h0};
			default:                    return 36'h0;
		endcase
	endfunction
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Feed one instruction; a reject checks only unsupported, others compare cycles, busy length, op, flags, pulses and operand fields, and the vector on a fault
	task automatic run_one(input logic [31:0] e, input iid_op_t xop);
		logic [7:0] b [3];
		int         nb, k, n, nbz;
		logic       mem, fault, imm, alu;
		logic [5:0] xv;
		logic [7:0] xc;
		repeat (8) seed = lfsr(seed);
		b[0] = e[31:24];
		b[1] = e[23:16];
		b[2] = e[15:8];
		nb = int'(e[1:0]);
		if (e[4])
			b[nb-1][7:6] = seed[1:0];
		mem = e[4] && (b[nb-1][7:6] != 2'b11);
		imm = (b[0] == 8'h0f) && (b[1] == 8'hba);
		n = int'(seed[8:4]);
		fault = seed[9];
		prot_mode = ~e[7];
		scan_reps = seed[8:4];
		bound_in_range = ~fault;
		op_size32 = seed[10];
		for (int j = 0; j < nb; j++)
			fetch.send(b[j], int'(seed[13+2*j +: 2]));
		case (xop)
			OP_ASCII_ADD, OP_ASCII_SUB: xc = 8'h03;
			OP_ASCII_DIV:  xc = 8'h07;
			OP_ASCII_MUL:  xc = 8'h13;
			OP_PRIV_ADJ:   xc = 8'h09;
			OP_BLIT0, OP_BLIT1: xc = 8'h02;
			OP_ARRAY_LIM:  xc = fault ? 8'h08 : 8'h07;
			OP_SCAN_FWD:   xc = mem ? 8'(9 + n) : 8'h04;
			OP_SCAN_REV:   xc = mem ? 8'(11 + n) : 8'h04;
			OP_BIT_TST:    xc = (mem && !imm) ? 8'h07 : 8'h01;
			OP_BIT_CMP, OP_BIT_CLR, OP_BIT_SET:
				xc = (mem && !imm) ? 8'h08 : 8'h02;
			default:       xc = 8'h01;
		endcase
		k = 0;
		nbz = 0;
		do begin
			@(negedge clk_sys);
			if (k == 0)
				fetch.drop();
			if (busy === 1'b1)
				nbz++;
			k++;
		end while (exec_done !== 1'b1 && unsupported !== 1'b1 && k < 64);
		if (xop == OP_NONE) begin
			chk(36'(unsupported), 36'h1);
			return;
		end
		// Done shows in the cycle after the last busy one
		chk(36'(k - 1), 36'(xc));
		chk(36'(nbz), 36'(xc));
		chk(36'(cycles), 36'(xc));
		chk(36'(op), 36'(xop));
		chk({flag_update, flag_force, flag_force_val, flag_undef},
			fx(xop));
		chk({blit0_rewind, blit1_rewind, bound_fault},
			{xop == OP_BLIT0, xop == OP_BLIT1,
			xop == OP_ARRAY_LIM && fault});
		if (xop == OP_ARRAY_LIM && fault)
			chk(36'(int_vector), 36'h5);
		// Immediate length, width, direction and memory operand
		alu = (xop == OP_SUM || xop == OP_ADC || xop == OP_AND);
		xv = {(imm ? 3'h1 : 3'h0), alu && b[0][0],
			alu && b[0][7:4] != 4'h8 && !b[0][2] && b[0][1], mem};
		if (alu && b[0][7:4] != 4'h8 && b[0][2])
			xv[5:3] = b[0][0] ? (op_size32 ? 3'h4 : 3'h2) : 3'h1;
		else if (b[0][7:4] == 4'h8)
			xv[5:3] = (b[0][1] || !b[0][0]) ? 3'h1 :
				(op_size32 ? 3'h4 : 3'h2);
		chk({imm_len, wide, dir_to_reg, mem_operand}, xv);
	endtask
	task automatic complete_run();
		if (n_mismatch == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Reset three cycles, then two randomised passes over the table
	initial begin
		rstn = 1'b0;
		prot_mode = 1'b1;
		op_size32 = 1'b0;
		scan_reps = 5'h00;
		bound_in_range = 1'b1;
		repeat (3) @(negedge clk_sys);
		rstn = 1'b1;
		@(negedge clk_sys);
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 27; i++)
				run_one(tbl[i], xops[i]);
		complete_run();
	end
endmodule
